/* logic/scfg_bank.sv */
// Purpose: start-up and closed-loop configuration registers with decode
// Assumes: single clock, synchronous active-high reset, strobe port
// Notes:   all outputs registered; decoded values lag a write by one cycle
//
// Contract
// - align code 0h..1Ch maps to listed angle; 1Dh..1Fh flagged not applicable
// - first-cycle fraction code maps to 0.1 % up to 25 % of maximum speed
// - select bit 0 gives 0 Hz first cycle; 1 uses the fraction field
// - angle error ramp code maps to 0.01 up to 2 deg/ms
// - closed-loop register sits at offset 88h and resets to zero
// - manual handoff uses threshold field; auto bit lets device choose
`timescale 1ns/100ps

module scfg_bank (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic      [8:0]  o_align_angle_deg,
  output logic             o_align_valid,
  output logic      [7:0]  o_first_cycle_speed,
  output logic      [7:0]  o_angle_ramp_rate,
  output logic             o_handoff_auto,
  output logic      [9:0]  o_loop_switch_speed_threshold,
  output logic      [31:0] o_closed_loop_settings
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0] startup_ff;
  logic [31:0] nxt_startup;
  logic [31:0] closed_ff;
  logic [31:0] nxt_closed;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_startup = startup_ff;
    nxt_closed  = closed_ff;
    nxt_rdata   = 32'h0000_0000;
    if (i_wr) begin
      if (i_addr == scfg_pkg::STARTUP_TWO_OFFSET) begin
        nxt_startup = i_wdata;
      end else if (i_addr == scfg_pkg::CLOSED_LOOP_OFFSET) begin
        nxt_closed = i_wdata & scfg_pkg::CLOSED_LOOP_WR_MASK;
      end
    end
    // unmapped reads answer zero so software never sees stale data
    if (i_rd) begin
      if (i_addr == scfg_pkg::STARTUP_TWO_OFFSET) begin
        nxt_rdata = startup_ff;
      end else if (i_addr == scfg_pkg::CLOSED_LOOP_OFFSET) begin
        nxt_rdata = closed_ff;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      startup_ff <= scfg_pkg::STARTUP_TWO_RESET;
      closed_ff  <= scfg_pkg::CLOSED_LOOP_RESET;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      startup_ff <= nxt_startup;
      closed_ff  <= nxt_closed;
      rdata_ff   <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic [4:0] align_code;
  logic [3:0] fraction_code;
  logic [2:0] ramp_code;
  logic [4:0] threshold_code;

  assign align_code     = startup_ff[scfg_pkg::ALIGN_MSB:scfg_pkg::ALIGN_LSB];
  assign fraction_code  =
    startup_ff[scfg_pkg::FRACTION_MSB:scfg_pkg::FRACTION_LSB];
  assign ramp_code      = startup_ff[scfg_pkg::RAMP_MSB:scfg_pkg::RAMP_LSB];
  assign threshold_code =
    startup_ff[scfg_pkg::THRESHOLD_MSB:scfg_pkg::THRESHOLD_LSB];

  logic [8:0] align_deg_ff;
  logic [8:0] nxt_align_deg;
  logic       align_valid_ff;
  logic       nxt_align_valid;
  logic [7:0] first_speed_ff;
  logic [7:0] nxt_first_speed;
  logic [7:0] ramp_ff;
  logic [7:0] nxt_ramp;
  logic       auto_ff;
  logic       nxt_auto;
  logic [9:0] threshold_ff;
  logic [9:0] nxt_threshold;

  always_comb begin
    // codes past the table hold angle zero and drop the valid flag
    nxt_align_valid = (align_code <= scfg_pkg::ALIGN_LAST_CODE);
    nxt_align_deg   = 9'h000;
    if (nxt_align_valid) begin
      nxt_align_deg = scfg_pkg::ALIGN_DEG_TABLE[align_code];
    end
    // zero here means start the first open-loop cycle from 0 Hz
    nxt_first_speed = 8'h00;
    if (startup_ff[scfg_pkg::SPEED_SELECT_BIT]) begin
      nxt_first_speed = scfg_pkg::FRACTION_TABLE[fraction_code];
    end
    nxt_ramp = scfg_pkg::RAMP_TABLE[ramp_code];
    nxt_auto = startup_ff[scfg_pkg::AUTO_HANDOFF_BIT];
    // with auto handoff the threshold is not used; show zero instead
    nxt_threshold = 10'h000;
    if (!nxt_auto) begin
      nxt_threshold = scfg_pkg::THRESHOLD_TABLE[threshold_code];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      align_deg_ff   <= 9'h000;
      align_valid_ff <= 1'b1;
      first_speed_ff <= 8'h00;
      ramp_ff        <= 8'h01;
      auto_ff        <= 1'b0;
      threshold_ff   <= 10'h00a;
    end else begin
      align_deg_ff   <= nxt_align_deg;
      align_valid_ff <= nxt_align_valid;
      first_speed_ff <= nxt_first_speed;
      ramp_ff        <= nxt_ramp;
      auto_ff        <= nxt_auto;
      threshold_ff   <= nxt_threshold;
    end
  end

  assign o_rdata                       = rdata_ff;
  assign o_align_angle_deg             = align_deg_ff;
  assign o_align_valid                 = align_valid_ff;
  assign o_first_cycle_speed           = first_speed_ff;
  assign o_angle_ramp_rate             = ramp_ff;
  assign o_handoff_auto                = auto_ff;
  assign o_loop_switch_speed_threshold = threshold_ff;
  assign o_closed_loop_settings        = closed_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking chk_clk @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  chk_align_invalid_codes: assert property (
    align_code > 5'h1c |=> !o_align_valid && o_align_angle_deg == 9'd0)
    else $error("align code above 1ch not flagged");

  chk_align_last_code: assert property (
    align_code == 5'h1c |=> o_align_valid && o_align_angle_deg == 9'd350)
    else $error("align code 1ch not decoded to 350");

  chk_fraction_top: assert property (
    startup_ff[3] && fraction_code == 4'hf |=> o_first_cycle_speed == 8'd250)
    else $error("fraction code fh not 25 percent");

  chk_fraction_bottom: assert property (
    startup_ff[3] && fraction_code == 4'h0 |=> o_first_cycle_speed == 8'd1)
    else $error("fraction code 0h not 0.1 percent");

  chk_first_zero_hz: assert property (
    !startup_ff[3] |=> o_first_cycle_speed == 8'd0)
    else $error("select low must give 0 Hz first cycle");

  chk_ramp_ends: assert property (
    ramp_code == 3'h7 |=> o_angle_ramp_rate == 8'd200)
    else $error("ramp code 7h not 2 deg/ms");

  chk_closed_write_read: assert property (
    i_wr && i_addr == 8'h88 ##1 i_rd && i_addr == 8'h88 && !i_wr
    |=> o_rdata == ($past(i_wdata, 2) & 32'hfeff_fffd))
    else $error("closed-loop register readback mismatch");

  chk_closed_reserved: assert property (
    o_closed_loop_settings[24] == 1'b0 && o_closed_loop_settings[1] == 1'b0)
    else $error("closed-loop reserved bits not zero");

  chk_handoff_manual: assert property (
    !startup_ff[18] && threshold_code == 5'h1f
    |=> !o_handoff_auto && o_loop_switch_speed_threshold == 10'd500)
    else $error("manual handoff threshold wrong");

  chk_handoff_auto: assert property (
    startup_ff[18] |=> o_handoff_auto && o_loop_switch_speed_threshold == 0)
    else $error("auto handoff must clear threshold");

  // ---------------------------------------------------------------
  // reset values, checked through reset itself
  // ---------------------------------------------------------------

  chk_reset_closed: assert property (disable iff (1'b0)
    i_rst |=> o_closed_loop_settings == 32'h0000_0000)
    else $error("closed-loop register not zero after reset");

  chk_reset_rdata: assert property (disable iff (1'b0)
    i_rst |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero after reset");

  chk_reset_decode: assert property (disable iff (1'b0)
    i_rst |=> o_align_valid && o_angle_ramp_rate == 8'd1)
    else $error("decoded fields not at reset values");

  chk_reset_speed: assert property (disable iff (1'b0)
    i_rst |=> o_first_cycle_speed == 8'd0 && !o_handoff_auto)
    else $error("first-cycle speed not 0 Hz after reset");

  // ---------------------------------------------------------------
  // register port behaviour
  // ---------------------------------------------------------------

  chk_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data stands without a read");

  chk_unmapped_read: assert property (
    i_rd && i_addr != scfg_pkg::STARTUP_TWO_OFFSET
    && i_addr != scfg_pkg::CLOSED_LOOP_OFFSET |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");

  chk_closed_write_land: assert property (
    i_wr && i_addr == scfg_pkg::CLOSED_LOOP_OFFSET
    |=> o_closed_loop_settings ==
        ($past(i_wdata) & scfg_pkg::CLOSED_LOOP_WR_MASK))
    else $error("closed-loop write did not land");

  chk_closed_hold: assert property (
    !(i_wr && i_addr == scfg_pkg::CLOSED_LOOP_OFFSET)
    |=> $stable(o_closed_loop_settings))
    else $error("closed-loop register changed without a write");

  // ---------------------------------------------------------------
  // align and first-cycle decode
  // ---------------------------------------------------------------

  chk_align_first_code: assert property (
    align_code == 5'h00 |=> o_align_valid && o_align_angle_deg == 9'd0)
    else $error("align code 0h not 0 degrees");

  chk_align_mid_code: assert property (
    align_code == 5'h0b |=> o_align_angle_deg == 9'd135)
    else $error("align code bh not 135 degrees");

  chk_align_valid_range: assert property (
    align_code <= 5'h1c |=> o_align_valid)
    else $error("listed align code flagged not applicable");

  chk_align_upper_code: assert property (
    align_code == 5'h19 |=> o_align_angle_deg == 9'd315)
    else $error("align code 19h not 315 degrees");

  chk_fraction_mid: assert property (
    startup_ff[3] && fraction_code == 4'hc |=> o_first_cycle_speed == 8'd100)
    else $error("fraction code ch not 10 percent");

  chk_fraction_low: assert property (
    startup_ff[3] && fraction_code == 4'h4 |=> o_first_cycle_speed == 8'd10)
    else $error("fraction code 4h not 1 percent");

  chk_fraction_used: assert property (
    startup_ff[3] |=> o_first_cycle_speed != 8'd0)
    else $error("select high must use the fraction field");

  // ---------------------------------------------------------------
  // ramp and handoff decode
  // ---------------------------------------------------------------

  chk_ramp_bottom: assert property (
    ramp_code == 3'h0 |=> o_angle_ramp_rate == 8'd1)
    else $error("ramp code 0h not 0.01 deg/ms");

  chk_ramp_mid: assert property (
    ramp_code == 3'h5 |=> o_angle_ramp_rate == 8'd50)
    else $error("ramp code 5h not 0.5 deg/ms");

  chk_ramp_low: assert property (
    ramp_code == 3'h2 |=> o_angle_ramp_rate == 8'd10)
    else $error("ramp code 2h not 0.1 deg/ms");

  chk_handoff_bottom: assert property (
    !startup_ff[18] && threshold_code == 5'h00
    |=> o_loop_switch_speed_threshold == 10'd10)
    else $error("threshold code 0h not 1 percent");

  chk_handoff_step: assert property (
    !startup_ff[18] && threshold_code == 5'h14
    |=> o_loop_switch_speed_threshold == 10'd225)
    else $error("threshold code 14h not 22.5 percent");

  chk_handoff_used: assert property (
    !startup_ff[18] |=> !o_handoff_auto && o_loop_switch_speed_threshold != 0)
    else $error("manual handoff must show a threshold");

  // ---------------------------------------------------------------
  // scenario covers
  // ---------------------------------------------------------------

  cov_closed_write: cover property (i_wr && i_addr == 8'h88);
  cov_align_na: cover property (!o_align_valid);
  cov_first_fraction: cover property (o_first_cycle_speed != 8'd0);
  cov_auto_handoff: cover property (o_handoff_auto);

endmodule : scfg_bank

/* include/scfg_pkg.sv */
// Purpose: constants for the start-up and closed-loop configuration bank
// Assumes: 32-bit register port, byte offsets
// Notes:   decoded tables give speeds in 0.1 % steps, angles in degrees
package scfg_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  STARTUP_TWO_OFFSET   = 8'h80;
  localparam logic [7:0]  CLOSED_LOOP_OFFSET   = 8'h88;
  localparam logic [31:0] STARTUP_TWO_RESET    = 32'h0000_0000;
  localparam logic [31:0] CLOSED_LOOP_RESET    = 32'h0000_0000;
  // read-only zero bits of the closed-loop register (bits 24 and 1)
  localparam logic [31:0] CLOSED_LOOP_WR_MASK  = 32'hfeff_fffd;

  // ---------------------------------------------------------------
  // start-up register field positions
  // ---------------------------------------------------------------
  localparam int AUTO_HANDOFF_BIT  = 18;
  localparam int THRESHOLD_MSB     = 17;
  localparam int THRESHOLD_LSB     = 13;
  localparam int ALIGN_MSB         = 12;
  localparam int ALIGN_LSB         = 8;
  localparam int FRACTION_MSB      = 7;
  localparam int FRACTION_LSB      = 4;
  localparam int SPEED_SELECT_BIT  = 3;
  localparam int RAMP_MSB          = 2;
  localparam int RAMP_LSB          = 0;

  // ---------------------------------------------------------------
  // decode tables
  // ---------------------------------------------------------------
  localparam logic [4:0] ALIGN_LAST_CODE = 5'h1c;
  // degrees per align code
  localparam logic [8:0] ALIGN_DEG_TABLE [0:28] = '{
    9'd0,   9'd10,  9'd20,  9'd30,  9'd45,  9'd60,  9'd70,  9'd80,
    9'd90,  9'd110, 9'd120, 9'd135, 9'd150, 9'd160, 9'd170, 9'd180,
    9'd190, 9'd210, 9'd225, 9'd240, 9'd250, 9'd260, 9'd270, 9'd280,
    9'd290, 9'd315, 9'd330, 9'd340, 9'd350};
  // first-cycle speed, units of 0.1 % of maximum speed
  localparam logic [7:0] FRACTION_TABLE [0:15] = '{
    8'd1,   8'd3,   8'd5,   8'd7,   8'd10,  8'd15,  8'd20,  8'd25,
    8'd30,  8'd40,  8'd50,  8'd75,  8'd100, 8'd150, 8'd200, 8'd250};
  // angle error ramp, units of 0.01 deg/ms
  localparam logic [7:0] RAMP_TABLE [0:7] = '{
    8'd1, 8'd5, 8'd10, 8'd15, 8'd20, 8'd50, 8'd100, 8'd200};
  // handoff threshold, units of 0.1 % of maximum speed
  localparam logic [9:0] THRESHOLD_TABLE [0:31] = '{
    10'd10,  10'd20,  10'd30,  10'd40,  10'd50,  10'd60,  10'd70,  10'd80,
    10'd90,  10'd100, 10'd110, 10'd120, 10'd130, 10'd140, 10'd150, 10'd160,
    10'd170, 10'd180, 10'd190, 10'd200, 10'd225, 10'd250, 10'd275, 10'd300,
    10'd325, 10'd350, 10'd375, 10'd400, 10'd425, 10'd450, 10'd475, 10'd500};

endpackage : scfg_pkg

/* tb/scfg_bank_tb.sv */
// Purpose: self-checking bench for the start-up and closed-loop bank
// Assumes: strobe port, read data one cycle after the read strobe
// Notes:   decoded outputs checked one edge after the write edge
`timescale 1ns/100ps

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  err_count++; $display("[ERR] %0t got %h want %h", $time, a, e); end end

module scfg_bank_tb;
  typedef struct {
    logic [31:0] wd;
    logic [8:0]  ang;
    logic        vld;
    logic [7:0]  spd;
    logic [7:0]  rmp;
    logic        aut;
    logic [9:0]  thr;
  } scfg_row_type;

  logic        i_clk_sys = 1'b0;
  logic        i_rst     = 1'b1;
  logic [7:0]  i_addr    = 8'h00;
  logic [31:0] i_wdata   = 32'h0;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [31:0] o_rdata, o_closed_loop_settings;
  logic [8:0]  o_align_angle_deg;
  logic [7:0]  o_first_cycle_speed, o_angle_ramp_rate;
  logic        o_align_valid, o_handoff_auto;
  logic [9:0]  o_loop_switch_speed_threshold;
  int          err_count = 0;
  int          samples_checked = 0;
  // wdata, angle, valid, speed, ramp, auto, threshold
  scfg_row_type rows [4] = '{
    '{32'h0000_1cfa, 9'd350, 1'b1, 8'd250, 8'd10,  1'b0, 10'd10},
    '{32'h0003_e3f7, 9'd30,  1'b1, 8'd0,   8'd200, 1'b0, 10'd500},
    '{32'h0004_1d08, 9'd0,   1'b0, 8'd1,   8'd1,   1'b1, 10'd0},
    '{32'hfff8_1f4d, 9'd0,   1'b0, 8'd10,  8'd50,  1'b0, 10'd10}};

  always #4 i_clk_sys = ~i_clk_sys;

  scfg_bank i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_align_angle_deg(o_align_angle_deg), .o_align_valid(o_align_valid),
    .o_first_cycle_speed(o_first_cycle_speed),
    .o_angle_ramp_rate(o_angle_ramp_rate), .o_handoff_auto(o_handoff_auto),
    .o_loop_switch_speed_threshold(o_loop_switch_speed_threshold),
    .o_closed_loop_settings(o_closed_loop_settings));

  // ---------------------------------------------------------------
  // register port tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask : rd

  task automatic summarize;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1 `CHK(o_align_valid, 1'b1)
    `CHK(o_angle_ramp_rate, 8'd1)
    `CHK(o_first_cycle_speed, 8'd0)
    `CHK(o_closed_loop_settings, 32'h0)
    rd(8'h88, 32'h0);
    foreach (rows[i]) begin
      wr(8'h80, rows[i].wd);
      @(posedge i_clk_sys);
      #1 `CHK(o_align_angle_deg, rows[i].ang)
      `CHK(o_align_valid, rows[i].vld)
      `CHK(o_first_cycle_speed, rows[i].spd)
      `CHK(o_angle_ramp_rate, rows[i].rmp)
      `CHK(o_handoff_auto, rows[i].aut)
      `CHK(o_loop_switch_speed_threshold, rows[i].thr)
      rd(8'h80, rows[i].wd);
    end
    // reserved bits 24 and 1 stay zero
    wr(8'h88, 32'hffff_ffff);
    #1 `CHK(o_closed_loop_settings, 32'hfeff_fffd)
    // unmapped neighbour holds nothing
    wr(8'h84, 32'h1234_5678);
    rd(8'h84, 32'h0);
    // back-to-back reads, data stands one cycle only
    @(posedge i_clk_sys);
    i_rd <= 1'b1; i_addr <= 8'h80;
    @(posedge i_clk_sys);
    i_addr <= 8'h88;
    #1 `CHK(o_rdata, rows[3].wd)
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, 32'hfeff_fffd)
    @(posedge i_clk_sys);
    #1 `CHK(o_rdata, 32'h0)
    // write then read with no gap sees the masked new value
    @(posedge i_clk_sys);
    i_wr <= 1'b1; i_addr <= 8'h88; i_wdata <= 32'h0123_4567;
    @(posedge i_clk_sys);
    i_wr <= 1'b0; i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, 32'h0023_4565)
    // reset in mid-run clears the closed-loop register
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1 `CHK(o_closed_loop_settings, 32'h0)
    `CHK(o_loop_switch_speed_threshold, 10'd10)
    rd(8'h88, 32'h0);
    summarize();
  end

  // hang guard, far beyond the 59 cycles the run needs
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule : scfg_bank_tb
